// File: inc/pcg_map.svh
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
`define PCG_OFF_CSR 12'h000
`define PCG_OFF_MUL 12'h004
`define PCG_OFF_PRE 12'h008
`define PCG_OFF_CORE 12'h00C
`define PCG_OFF_PER 12'h010
`define PCG_OFF_EXT 12'h014
`define PCG_OFF_OSC 12'h018
`define PCG_OFF_CFG 12'h01C
`define PCG_OFF_GBL 12'h020
`define PCG_CSR_PATH 0
`define PCG_CSR_RST 3
`define PCG_CSR_STABLE 6
`define PCG_DIV_EN 15
`define PCG_CFG_MEMSRC 4
`define PCG_GBL_PERPIN 3
`define PCG_GBL_MEMPIN 5
`define PCG_RST_CSR 32'h0000_0008
`define PCG_RST_MUL 32'h0000_0004
`define PCG_RST_PRE 32'h0000_8000
`define PCG_RST_CORE 32'h0000_8000
`define PCG_RST_PER 32'h0000_8001
`define PCG_RST_EXT 32'h0000_8001
`define PCG_RST_OSC 32'h0000_8000
`define PCG_RST_CFG 32'h0000_0000
`define PCG_RST_GBL 32'h0000_0028
`define PCG_MUL_MIN 5'h04
`define PCG_MUL_MAX 5'h19
`define PCG_CLK_PERIOD_NS 8
`define PCG_LOCK_MAX_NS 187500
`define PCG_LOCK_CYCLES (`PCG_LOCK_MAX_NS / `PCG_CLK_PERIOD_NS)
`endif

// File: inc/pcg_pkg.sv
package pcg_pkg;
    typedef struct packed {
        logic enable;
        logic [4:0] ratio;
    } pcg_div_cfg_t;
    typedef enum logic [2:0] {
        PCG_PLL_RESET = 3'h1,
        PCG_PLL_LOCKING = 3'h2,
        PCG_PLL_LOCKED = 3'h4
    } pcg_pll_state_t;
    typedef struct packed {
        logic core;
        logic periph;
        logic extmem;
    } pcg_sys_tick_t;
endpackage : pcg_pkg

// File: hdl/pcg_divider.sv
`timescale 1ns/1ps
module pcg_divider (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tickIn,
    input wire pcg_pkg::pcg_div_cfg_t cfg,
    output logic tickOut
);
    import pcg_pkg::*;
    logic [4:0] count_reg, count_next;
    pcg_div_cfg_t act_reg, act_next;
    logic tickOut_reg, tickOut_next;
    logic wrap;

    assign wrap = tickIn && (count_reg == act_reg.ratio);
    assign tickOut = tickOut_reg;

    // new ratio and enable are taken only at a period end, so no runt pulse
    always_comb begin
        count_next = count_reg;
        act_next = act_reg;
        tickOut_next = 1'b0;
        if (wrap) begin
            count_next = 5'h0;
            act_next = cfg;
            tickOut_next = act_reg.enable;
        end else if (tickIn) begin
            count_next = count_reg + 5'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_reg <= 5'h0;
            act_reg <= '0;
            tickOut_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            act_reg <= act_next;
            tickOut_reg <= tickOut_next;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_ratio_at_wrap;
        $changed(act_reg) |-> $past(wrap);
    endproperty
    a_ratio_at_wrap: assert property (p_ratio_at_wrap) else $error("ratio changed mid period");

    property p_out_at_wrap;
        tickOut_reg |-> $past(wrap) && count_reg == 5'h0 && $past(act_reg.enable);
    endproperty
    a_out_at_wrap: assert property (p_out_at_wrap) else $error("divided tick off boundary");

    c_two_outs: cover property (tickOut_reg ##[1:64] tickOut_reg);
endmodule : pcg_divider

// File: hdl/pcg_pll_model.sv
`timescale 1ns/1ps
`include "pcg_map.svh"
module pcg_pll_model #(
    parameter int LOCK_CYCLES = `PCG_LOCK_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic resetCtl,
    input wire logic refTick,
    input wire logic [4:0] multFactor,
    output logic pllTick,
    output logic locked
);
    import pcg_pkg::*;
    pcg_pll_state_t state_reg, state_next;
    logic [14:0] lockCnt_reg, lockCnt_next;
    logic [5:0] acc_reg, acc_next;
    logic pllTick_reg, pllTick_next;
    logic [4:0] mult_reg;
    logic [5:0] credit;

    assign pllTick = pllTick_reg;
    assign locked = (state_reg == PCG_PLL_LOCKED);
    assign credit = refTick ? {1'b0, multFactor} : 6'h0;

    // phase accumulator: output rate = reference rate * factor / 25, the
    // scale keeps even x25 at no more than one tick per cycle
    always_comb begin
        state_next = state_reg;
        lockCnt_next = lockCnt_reg;
        acc_next = acc_reg;
        pllTick_next = 1'b0;
        case (state_reg)
            PCG_PLL_RESET: begin
                lockCnt_next = 15'h0;
                acc_next = 6'h0;
                if (!resetCtl) state_next = PCG_PLL_LOCKING;
            end
            PCG_PLL_LOCKING: begin
                lockCnt_next = lockCnt_reg + 15'h1;
                if (lockCnt_reg == 15'(LOCK_CYCLES - 1)) state_next = PCG_PLL_LOCKED;
            end
            PCG_PLL_LOCKED: begin
                if (acc_reg >= {1'b0, `PCG_MUL_MAX}) begin
                    acc_next = acc_reg - {1'b0, `PCG_MUL_MAX} + credit;
                    pllTick_next = 1'b1;
                end else begin
                    acc_next = acc_reg + credit;
                end
            end
            default: state_next = PCG_PLL_RESET;
        endcase
        if (state_reg != PCG_PLL_RESET && multFactor != mult_reg) begin
            state_next = PCG_PLL_LOCKING;
            lockCnt_next = 15'h0;
        end
        // a tick launched in the cycle that reset is asserted would leave the reset pll
        if (resetCtl) begin
            state_next = PCG_PLL_RESET;
            pllTick_next = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= PCG_PLL_RESET;
            lockCnt_reg <= 15'h0;
            acc_reg <= 6'h0;
            pllTick_reg <= 1'b0;
            mult_reg <= `PCG_MUL_MIN;
        end else begin
            state_reg <= state_next;
            lockCnt_reg <= lockCnt_next;
            acc_reg <= acc_next;
            pllTick_reg <= pllTick_next;
            mult_reg <= multFactor;
        end
    end

    logic [15:0] relWait;
    always_ff @(posedge clock) begin
        // a relock starts its count at one, as the release from reset does
        if (sys_rst || resetCtl) relWait <= 16'h0;
        else if (multFactor != mult_reg) relWait <= 16'h1;
        else if (locked) relWait <= 16'h0;
        else relWait <= relWait + 16'h1;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_tick_locked;
        pllTick_reg |-> $past(locked) && !$past(resetCtl);
    endproperty
    a_tick_locked: assert property (p_tick_locked) else $error("pll tick while unlocked");

    property p_lock_time;
        $rose(locked) |-> $past(relWait) == 16'(LOCK_CYCLES);
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("lock time wrong");

    c_locked: cover property ($rose(locked));
endmodule : pcg_pll_model

// File: hdl/pcg_clock_gen.sv
`timescale 1ns/1ps
`include "pcg_map.svh"
// How it works
// - pre-divider plus three post-dividers
// - periph pin: bus clock, two enables
// - aux pin: oscillator divider, gated
// - memory pin: internal or external source
// - raw input clock to audio ports
// - oscillator divider one to thirty-two
// - pre-divide then multiply four to 25
// - path select: raw or pll
// - three independent system clock dividers
// - pll reset bit resets to one
module pcg_clock_gen #(
    parameter int LOCK_CYCLES = `PCG_LOCK_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic memoryClockIn,
    output logic coreClock,
    output logic periphBusClock,
    output logic extmemClock,
    output logic periphClockPin,
    output logic auxClockPin,
    output logic memoryClockOut,
    output logic audioAuxClock,
    output logic pllLocked
);
    import pcg_pkg::*;

    function automatic pcg_div_cfg_t divWrite(input logic [31:0] d);
        divWrite = '{enable: d[`PCG_DIV_EN], ratio: d[4:0]};
    endfunction : divWrite

    function automatic logic [31:0] divRead(input pcg_div_cfg_t c);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[`PCG_DIV_EN] = c.enable;
        r[4:0] = c.ratio;
        divRead = r;
    endfunction : divRead

    function automatic logic [4:0] clampMult(input logic [4:0] m);
        if (m < `PCG_MUL_MIN) clampMult = `PCG_MUL_MIN;
        else if (m > `PCG_MUL_MAX) clampMult = `PCG_MUL_MAX;
        else clampMult = m;
    endfunction : clampMult

    // register file
    logic pathSel_reg, pathSel_next;
    logic rstCtl_reg, rstCtl_next;
    logic [4:0] mult_reg, mult_next;
    pcg_div_cfg_t preCfg_reg, preCfg_next;
    pcg_div_cfg_t coreCfg_reg, coreCfg_next;
    pcg_div_cfg_t perCfg_reg, perCfg_next;
    pcg_div_cfg_t extCfg_reg, extCfg_next;
    pcg_div_cfg_t oscCfg_reg, oscCfg_next;
    logic memSrc_reg, memSrc_next;
    logic perPin_reg, perPin_next;
    logic memPin_reg, memPin_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [31:0] csrRst, rdVal;
    logic hit, wrEn, setup;

    assign csrRst = `PCG_RST_CSR;
    assign setup = psel && !penable;
    assign wrEn = psel && penable && pwrite && hit;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_reg;

    // read data is captured in the setup cycle so it stands in the access cycle
    always_comb begin
        hit = 1'b1;
        rdVal = 32'h0000_0000;
        case (paddr)
            `PCG_OFF_CSR: begin
                rdVal[`PCG_CSR_PATH] = pathSel_reg;
                rdVal[`PCG_CSR_RST] = rstCtl_reg;
                rdVal[`PCG_CSR_STABLE] = pllLocked;
            end
            `PCG_OFF_MUL: rdVal[4:0] = mult_reg;
            `PCG_OFF_PRE: rdVal = divRead(preCfg_reg);
            `PCG_OFF_CORE: rdVal = divRead(coreCfg_reg);
            `PCG_OFF_PER: rdVal = divRead(perCfg_reg);
            `PCG_OFF_EXT: rdVal = divRead(extCfg_reg);
            `PCG_OFF_OSC: rdVal = divRead(oscCfg_reg);
            `PCG_OFF_CFG: rdVal[`PCG_CFG_MEMSRC] = memSrc_reg;
            `PCG_OFF_GBL: begin
                rdVal[`PCG_GBL_PERPIN] = perPin_reg;
                rdVal[`PCG_GBL_MEMPIN] = memPin_reg;
            end
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        pathSel_next = pathSel_reg;
        rstCtl_next = rstCtl_reg;
        mult_next = mult_reg;
        preCfg_next = preCfg_reg;
        coreCfg_next = coreCfg_reg;
        perCfg_next = perCfg_reg;
        extCfg_next = extCfg_reg;
        oscCfg_next = oscCfg_reg;
        memSrc_next = memSrc_reg;
        perPin_next = perPin_reg;
        memPin_next = memPin_reg;
        prdata_next = setup ? rdVal : prdata_reg;
        if (wrEn) begin
            case (paddr)
                `PCG_OFF_CSR: begin
                    pathSel_next = pwdata[`PCG_CSR_PATH];
                    rstCtl_next = pwdata[`PCG_CSR_RST];
                end
                // out-of-range factors are clamped so the model never overruns
                `PCG_OFF_MUL: mult_next = clampMult(pwdata[4:0]);
                `PCG_OFF_PRE: preCfg_next = divWrite(pwdata);
                `PCG_OFF_CORE: coreCfg_next = divWrite(pwdata);
                `PCG_OFF_PER: perCfg_next = divWrite(pwdata);
                `PCG_OFF_EXT: extCfg_next = divWrite(pwdata);
                `PCG_OFF_OSC: oscCfg_next = divWrite(pwdata);
                `PCG_OFF_CFG: memSrc_next = pwdata[`PCG_CFG_MEMSRC];
                `PCG_OFF_GBL: begin
                    perPin_next = pwdata[`PCG_GBL_PERPIN];
                    memPin_next = pwdata[`PCG_GBL_MEMPIN];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pathSel_reg <= csrRst[`PCG_CSR_PATH];
            rstCtl_reg <= csrRst[`PCG_CSR_RST];
            mult_reg <= 5'(`PCG_RST_MUL);
            preCfg_reg <= divWrite(`PCG_RST_PRE);
            coreCfg_reg <= divWrite(`PCG_RST_CORE);
            perCfg_reg <= divWrite(`PCG_RST_PER);
            extCfg_reg <= divWrite(`PCG_RST_EXT);
            oscCfg_reg <= divWrite(`PCG_RST_OSC);
            memSrc_reg <= 1'b0;
            perPin_reg <= 1'b1;
            memPin_reg <= 1'b1;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pathSel_reg <= pathSel_next;
            rstCtl_reg <= rstCtl_next;
            mult_reg <= mult_next;
            preCfg_reg <= preCfg_next;
            coreCfg_reg <= coreCfg_next;
            perCfg_reg <= perCfg_next;
            extCfg_reg <= extCfg_next;
            oscCfg_reg <= oscCfg_next;
            memSrc_reg <= memSrc_next;
            perPin_reg <= perPin_next;
            memPin_reg <= memPin_next;
            prdata_reg <= prdata_next;
        end
    end

    // clock path; each derived clock is a one-cycle tick per divided period
    logic refTick, pllTick, hfTick, oscTick;
    pcg_sys_tick_t sysTick;

    pcg_divider uPreDiv (
        .clock(clock),
        .sys_rst(sys_rst),
        .tickIn(1'b1),
        .cfg(preCfg_reg),
        .tickOut(refTick)
    );

    pcg_pll_model #(.LOCK_CYCLES(LOCK_CYCLES)) uPll (
        .clock(clock),
        .sys_rst(sys_rst),
        .resetCtl(rstCtl_reg),
        .refTick(refTick),
        .multFactor(mult_reg),
        .pllTick(pllTick),
        .locked(pllLocked)
    );

    // both sources are single-cycle ticks, so switching cannot cut a pulse
    assign hfTick = pathSel_reg ? pllTick : 1'b1;

    pcg_divider uCoreDiv (
        .clock(clock),
        .sys_rst(sys_rst),
        .tickIn(hfTick),
        .cfg(coreCfg_reg),
        .tickOut(sysTick.core)
    );

    pcg_divider uPerDiv (
        .clock(clock),
        .sys_rst(sys_rst),
        .tickIn(hfTick),
        .cfg(perCfg_reg),
        .tickOut(sysTick.periph)
    );

    pcg_divider uExtDiv (
        .clock(clock),
        .sys_rst(sys_rst),
        .tickIn(hfTick),
        .cfg(extCfg_reg),
        .tickOut(sysTick.extmem)
    );

    pcg_divider uOscDiv (
        .clock(clock),
        .sys_rst(sys_rst),
        .tickIn(1'b1),
        .cfg(oscCfg_reg),
        .tickOut(oscTick)
    );

    // external memory clock pin is asynchronous: two flops before use
    logic memSync1_reg, memSync2_reg;
    logic perPinOut_reg, perPinOut_next;
    logic auxPinOut_reg, auxPinOut_next;
    logic memOut_reg, memOut_next;
    logic audio_reg;

    always_comb begin
        perPinOut_next = sysTick.periph && perCfg_reg.enable && perPin_reg;
        auxPinOut_next = oscTick;
        memOut_next = 1'b0;
        if (memPin_reg) begin
            memOut_next = memSrc_reg ? memSync2_reg : sysTick.extmem;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            memSync1_reg <= 1'b0;
            memSync2_reg <= 1'b0;
            perPinOut_reg <= 1'b0;
            auxPinOut_reg <= 1'b0;
            memOut_reg <= 1'b0;
            audio_reg <= 1'b0;
        end else begin
            memSync1_reg <= memoryClockIn;
            memSync2_reg <= memSync1_reg;
            perPinOut_reg <= perPinOut_next;
            auxPinOut_reg <= auxPinOut_next;
            memOut_reg <= memOut_next;
            audio_reg <= 1'b1;
        end
    end

    assign coreClock = sysTick.core;
    assign periphBusClock = sysTick.periph;
    assign extmemClock = sysTick.extmem;
    assign periphClockPin = perPinOut_reg;
    assign auxClockPin = auxPinOut_reg;
    assign memoryClockOut = memOut_reg;
    assign audioAuxClock = audio_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_rst_ctl;
        @(posedge clock) disable iff (1'b0) $past(sys_rst) |-> rstCtl_reg && !pathSel_reg;
    endproperty
    a_rst_ctl: assert property (p_rst_ctl) else $error("pll reset bit not set by reset");

    property p_periph_pin;
        ##1 periphClockPin == $past(periphBusClock && perCfg_reg.enable && perPin_reg);
    endproperty
    a_periph_pin: assert property (p_periph_pin) else $error("periph pin mismatch");

    property p_aux_pin;
        oscTick |=> auxClockPin;
    endproperty
    a_aux_pin: assert property (p_aux_pin) else $error("aux pin missed tick");

    property p_mem_ext;
        memSrc_reg && memPin_reg && memoryClockIn ##1 memSrc_reg && memPin_reg
            ##1 memSrc_reg && memPin_reg |=> memoryClockOut;
    endproperty
    a_mem_ext: assert property (p_mem_ext) else $error("memory pin ignores input");

    property p_mem_off;
        !memPin_reg |=> !memoryClockOut;
    endproperty
    a_mem_off: assert property (p_mem_off) else $error("memory pin not gated");

    property p_audio;
        ##1 1'b1 |-> audioAuxClock;
    endproperty
    a_audio: assert property (p_audio) else $error("audio clock missing");

    property p_bypass;
        !pathSel_reg |-> hfTick;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not raw clock");

    property p_osc_rate;
        oscCfg_reg.enable && oscCfg_reg.ratio == 5'h1 && $stable(oscCfg_reg) && oscTick
            |-> ##1 !oscTick ##1 oscTick;
    endproperty
    a_osc_rate: assert property (p_osc_rate) else $error("osc divide by two wrong");

    c_pll_path: cover property (pathSel_reg && pllLocked && coreClock);
    c_mem_ext: cover property (memSrc_reg && memoryClockOut);
    c_slverr: cover property (pslverr);
endmodule : pcg_clock_gen

// File: test/pcg_clock_gen_bench.sv
`timescale 1ns/1ps
`include "pcg_map.svh"
module pcg_clock_gen_bench;
    import pcg_pkg::*;
    localparam int LOCK = 20;
    logic clock;
    logic sysRst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic memoryClockIn = 1'b0;
    logic coreClock;
    logic periphBusClock;
    logic extmemClock;
    logic periphClockPin;
    logic auxClockPin;
    logic memoryClockOut;
    logic audioAuxClock;
    logic pllLocked;
    logic memToggle;
    int memDiv = 0;
    int n_mismatch;
    int tests_run;
    logic [31:0] rdData;
    logic rdErr;
    int n;
    logic [11:0] offs [9] = '{`PCG_OFF_CSR, `PCG_OFF_MUL, `PCG_OFF_PRE, `PCG_OFF_CORE,
        `PCG_OFF_PER, `PCG_OFF_EXT, `PCG_OFF_OSC, `PCG_OFF_CFG, `PCG_OFF_GBL};
    logic [31:0] rstVals [9] = '{`PCG_RST_CSR, `PCG_RST_MUL, `PCG_RST_PRE, `PCG_RST_CORE,
        `PCG_RST_PER, `PCG_RST_EXT, `PCG_RST_OSC, `PCG_RST_CFG, `PCG_RST_GBL};
    // ticks per 40 cycles at reset ratios: core, bus, extmem, pins, audio
    int defCount [7] = '{40, 20, 20, 20, 40, 20, 40};

    pcg_clock_gen #(.LOCK_CYCLES(LOCK)) pcg_clock_gen_i (
        .clock(clock), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .memoryClockIn(memoryClockIn), .coreClock(coreClock), .periphBusClock(periphBusClock),
        .extmemClock(extmemClock), .periphClockPin(periphClockPin), .auxClockPin(auxClockPin),
        .memoryClockOut(memoryClockOut), .audioAuxClock(audioAuxClock), .pllLocked(pllLocked)
    );

    always #4 clock = ~clock;

    // external memory clock of period 6, free of the system clock's divider logic
    always @(posedge clock) begin
        if (memToggle) begin
            memDiv <= (memDiv == 2) ? 0 : memDiv + 1;
            if (memDiv == 2) begin
                memoryClockIn <= ~memoryClockIn;
            end
        end
    end

    task automatic conclude();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clock);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (k == 50) begin
            n_mismatch++;
            conclude();
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic pick(input int sel);
        case (sel)
            0: return coreClock;
            1: return periphBusClock;
            2: return extmemClock;
            3: return periphClockPin;
            4: return auxClockPin;
            5: return memoryClockOut;
            default: return audioAuxClock;
        endcase
    endfunction : pick

    // counting over a whole number of periods makes the result phase independent
    task automatic count_high(input int sel, input int cycles, input int exp, input string name);
        int c;
        c = 0;
        repeat (cycles) begin
            @(posedge clock);
            #1;
            if (pick(sel) === 1'b1) begin
                c++;
            end
        end
        check(name, exp, c);
    endtask : count_high

    initial begin
        clock = 1'b0;
        sysRst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        memToggle = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (6) @(posedge clock);
        sysRst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, offs[i], 32'h0000_0000);
            check("resetValue", rstVals[i], rdData);
        end
        repeat (10) @(posedge clock);
        for (int s = 0; s < 7; s++) begin
            count_high(s, 40, defCount[s], "defaultClock");
        end
        apb(1'b1, `PCG_OFF_CSR, 32'h0000_0008);
        repeat (16) @(posedge clock);
        apb(1'b1, `PCG_OFF_MUL, 32'h0000_0005);
        apb(1'b1, `PCG_OFF_CSR, 32'h0000_0000);
        n = 0;
        while (pllLocked !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("lockDelay", LOCK + 1, n);
        apb(1'b0, `PCG_OFF_CSR, 32'h0000_0000);
        check("csrLocked", 32'h0000_0040, rdData);
        apb(1'b1, `PCG_OFF_CSR, 32'h0000_0001);
        repeat (20) @(posedge clock);
        count_high(0, 50, 10, "coreOnPll");
        count_high(1, 50, 5, "busOnPll");
        apb(1'b1, `PCG_OFF_CSR, 32'h0000_0000);
        repeat (10) @(posedge clock);
        count_high(0, 20, 20, "coreBypass");
        apb(1'b1, `PCG_OFF_CSR, 32'h0000_0008);
        apb(1'b0, `PCG_OFF_CSR, 32'h0000_0000);
        check("csrReset", 32'h0000_0008, rdData);
        apb(1'b1, `PCG_OFF_MUL, 32'h0000_0002);
        apb(1'b0, `PCG_OFF_MUL, 32'h0000_0000);
        check("mulLow", 32'h0000_0004, rdData);
        apb(1'b1, `PCG_OFF_MUL, 32'h0000_001E);
        apb(1'b0, `PCG_OFF_MUL, 32'h0000_0000);
        check("mulHigh", 32'h0000_0019, rdData);
        // slowing down: bus divider first so the bus never outruns half the core
        apb(1'b1, `PCG_OFF_PER, 32'h0000_8005);
        apb(1'b1, `PCG_OFF_CORE, 32'h0000_8002);
        apb(1'b1, `PCG_OFF_EXT, 32'h0000_8003);
        repeat (40) @(posedge clock);
        count_high(0, 60, 20, "coreDiv3");
        count_high(1, 60, 10, "busDiv6");
        count_high(3, 60, 10, "periphPinDiv6");
        count_high(5, 40, 10, "memOutDiv4");
        apb(1'b1, `PCG_OFF_GBL, 32'h0000_0020);
        repeat (5) @(posedge clock);
        count_high(3, 40, 0, "periphPinOff");
        apb(1'b1, `PCG_OFF_GBL, 32'h0000_0008);
        repeat (5) @(posedge clock);
        count_high(5, 40, 0, "memOutOff");
        memToggle <= 1'b1;
        apb(1'b1, `PCG_OFF_GBL, 32'h0000_0028);
        apb(1'b1, `PCG_OFF_CFG, 32'h0000_0010);
        repeat (20) @(posedge clock);
        count_high(5, 60, 30, "memOutExternal");
        apb(1'b1, `PCG_OFF_OSC, 32'h0000_001F);
        repeat (10) @(posedge clock);
        count_high(4, 40, 0, "auxOff");
        apb(1'b1, `PCG_OFF_OSC, 32'h0000_801F);
        repeat (70) @(posedge clock);
        count_high(4, 64, 2, "auxDiv32");
        apb(1'b1, `PCG_OFF_OSC, 32'h0000_8001);
        repeat (40) @(posedge clock);
        count_high(4, 40, 20, "auxDiv2");
        count_high(6, 20, 20, "audioAux");
        apb(1'b1, 12'h024, 32'hFFFF_FFFF);
        check("unmappedWrErr", 32'h0000_0001, {31'h0000_0000, rdErr});
        apb(1'b0, 12'h024, 32'h0000_0000);
        check("unmappedRdErr", 32'h0000_0001, {31'h0000_0000, rdErr});
        check("unmappedRdData", 32'h0000_0000, rdData);
        conclude();
    end
endmodule : pcg_clock_gen_bench
